//--- rtl/rps_pkg.sv
// constants for the redundant pair switch controller
package rps_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned PULSE_MS        = 350;
    localparam int unsigned PULSE_CYC       = (CLK_HZ / 1000) * PULSE_MS;
    localparam int unsigned HB_HALF_MS      = 1000;
    localparam int unsigned HB_HALF_CYC     = (CLK_HZ / 1000) * HB_HALF_MS;
    localparam int unsigned DEB_MS          = 5;
    localparam int unsigned DEB_CYC         = (CLK_HZ / 1000) * DEB_MS;
    localparam int unsigned SETTLE_CYC      = 2;
    localparam int unsigned CNT_W           = 26;
    typedef enum logic [1:0] {
        RPS_IDLE,
        RPS_PULSE,
        RPS_CHECK
    } rps_state_t;
endpackage

//--- rtl/rps_ctrl.sv
// redundant pair switch controller: unit health, waveguide switches, customer contacts
// Function
// - drive go-to-A or go-to-B pulse 350 ms, Tx and Rx switches alike.
// - switch position read from A and B indicators, shorted means that position.
// - unit health input shorted means healthy, open means faulted.
// - unit A position output grounded while A online, open otherwise.
// - unit B position output grounded while B online, open otherwise.
// - pair-mode flag outputs to both units held at ground.
// - second-unit address select toward unit B held at ground.
// - first/second online contacts closed while A/B online respectively.
// - fault contacts closed while the matching unit is faulted.
// - select input grounded means manual mode, open means automatic.
// - heartbeat output to each unit reports controller and switch condition.
// - auxiliary serial line driven to each unit, its return received.
// - Tx and Rx switches always commanded together to the same position.
// - heartbeat is half-hertz square wave, stops toggling on a switch fault.
// - auto mode swaps when online unit faults, unless offline unit faulted too.
// - swap request in RPS_IDLE always swaps in manual, in auto only if offline healthy.
`timescale 1ns/1ps
`default_nettype none
module rps_ctrl
    import rps_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = rps_pkg::PULSE_CYC,
    parameter int unsigned HB_CYCLES    = rps_pkg::HB_HALF_CYC,
    parameter int unsigned DEB_CYCLES   = rps_pkg::DEB_CYC
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic clk_en_i,
    input  wire logic unit_a_health_in_n_i,
    input  wire logic unit_b_health_in_n_i,
    input  wire logic auto_manual_select_in_n_i,
    input  wire logic swap_req_n_i,
    input  wire logic tx_ind_a_n_i,
    input  wire logic tx_ind_b_n_i,
    input  wire logic rx_ind_a_n_i,
    input  wire logic rx_ind_b_n_i,
    input  wire logic aux_serial_tx_a_i,
    input  wire logic aux_serial_tx_b_i,
    input  wire logic aux_serial_from_unit_a_i,
    input  wire logic aux_serial_from_unit_b_i,
    output logic      aux_serial_to_unit_a_o,
    output logic      aux_serial_to_unit_b_o,
    output logic      aux_serial_rx_a_o,
    output logic      aux_serial_rx_b_o,
    output logic      tx_goto_a_o,
    output logic      tx_goto_b_o,
    output logic      rx_goto_a_o,
    output logic      rx_goto_b_o,
    output logic      pos_a_oe_n_o,
    output logic      pos_b_oe_n_o,
    output logic      pair_mode_a_oe_n_o,
    output logic      pair_mode_b_oe_n_o,
    output logic      b_addr_sel_oe_n_o,
    output logic      switch_health_heartbeat_a_o,
    output logic      switch_health_heartbeat_b_o,
    output logic      first_online_contact_o,
    output logic      second_online_contact_o,
    output logic      unit_a_fault_contact_o,
    output logic      unit_b_fault_contact_o,
    output logic      manual_mode_o,
    output logic      switch_fault_o,
    output logic      online_b_o
);
    import rps_pkg::*;

    // debounced inputs: 0 health, 1 health, 2 select, 3 swap (all active low raw)
    logic [3:0]       raw_w;
    logic [3:0]       deb_q;
    logic [CNT_W-1:0] deb_cnt_q [4];
    assign raw_w = {swap_req_n_i, auto_manual_select_in_n_i,
                    unit_b_health_in_n_i, unit_a_health_in_n_i};

    // level accepted only after it held steady for DEB_CYCLES
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            deb_q <= 4'hf;
            for (int i = 0; i < 4; i++) deb_cnt_q[i] <= '0;
        end else if (clk_en_i) begin
            for (int i = 0; i < 4; i++) begin
                if (raw_w[i] == deb_q[i]) begin
                    deb_cnt_q[i] <= '0;
                end else if (deb_cnt_q[i] >= CNT_W'(DEB_CYCLES - 1)) begin
                    deb_q[i]     <= raw_w[i];
                    deb_cnt_q[i] <= '0;
                end else begin
                    deb_cnt_q[i] <= deb_cnt_q[i] + CNT_W'(1);
                end
            end
        end
    end

    logic a_faulted_w;
    logic b_faulted_w;
    logic manual_w;
    logic swap_lvl_w;
    logic swap_q;
    logic swap_evt_w;
    assign a_faulted_w = deb_q[0];
    assign b_faulted_w = deb_q[1];
    assign manual_w    = !deb_q[2];
    assign swap_lvl_w  = !deb_q[3];
    // debounce stays below 100 ms, so a legal request is always seen
    assign swap_evt_w  = swap_lvl_w && !swap_q;

    rps_state_t       state_q;
    logic             online_b_q;
    logic [CNT_W-1:0] pulse_cnt_q;
    logic             sw_fault_q;
    logic             online_flt_w;
    logic             offline_flt_w;
    logic             go_w;
    logic             tx_pos_ok_w;
    logic             rx_pos_ok_w;

    assign online_flt_w  = online_b_q ? b_faulted_w : a_faulted_w;
    assign offline_flt_w = online_b_q ? a_faulted_w : b_faulted_w;
    assign go_w = (state_q == RPS_IDLE) &&
                  ((!manual_w && online_flt_w && !offline_flt_w) ||
                   (swap_evt_w && (manual_w || !offline_flt_w)));
    // shorted indicator (low) marks the position reached
    assign tx_pos_ok_w = online_b_q ? (!tx_ind_b_n_i && tx_ind_a_n_i)
                                    : (!tx_ind_a_n_i && tx_ind_b_n_i);
    assign rx_pos_ok_w = online_b_q ? (!rx_ind_b_n_i && rx_ind_a_n_i)
                                    : (!rx_ind_a_n_i && rx_ind_b_n_i);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q     <= RPS_IDLE;
            online_b_q  <= 1'b0;
            pulse_cnt_q <= '0;
            sw_fault_q  <= 1'b0;
            swap_q      <= 1'b0;
        end else if (clk_en_i) begin
            swap_q <= swap_lvl_w;
            case (state_q)
                RPS_IDLE: begin
                    if (go_w) begin
                        online_b_q  <= !online_b_q;
                        pulse_cnt_q <= '0;
                        state_q     <= RPS_PULSE;
                    end
                end
                RPS_PULSE: begin
                    if (pulse_cnt_q == CNT_W'(PULSE_CYCLES - 1)) begin
                        pulse_cnt_q <= '0;
                        state_q     <= RPS_CHECK;
                    end else begin
                        pulse_cnt_q <= pulse_cnt_q + CNT_W'(1);
                    end
                end
                RPS_CHECK: begin
                    if (pulse_cnt_q == CNT_W'(SETTLE_CYC - 1)) begin
                        sw_fault_q <= !(tx_pos_ok_w && rx_pos_ok_w);
                        state_q    <= RPS_IDLE;
                    end else begin
                        pulse_cnt_q <= pulse_cnt_q + CNT_W'(1);
                    end
                end
                default: state_q <= RPS_IDLE;
            endcase
        end
    end

    // heartbeat: 1 s half period gives 0.5 Hz; frozen while a switch fault stands
    logic             hb_q;
    logic [CNT_W-1:0] hb_cnt_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hb_q     <= 1'b0;
            hb_cnt_q <= '0;
        end else if (clk_en_i) begin
            if (sw_fault_q) begin
                hb_cnt_q <= '0;
            end else if (hb_cnt_q == CNT_W'(HB_CYCLES - 1)) begin
                hb_cnt_q <= '0;
                hb_q     <= !hb_q;
            end else begin
                hb_cnt_q <= hb_cnt_q + CNT_W'(1);
            end
        end
    end

    logic pulsing_w;
    assign pulsing_w = (state_q == RPS_PULSE);

    // own count of the command length, so the length check does not lean on pulse_cnt_q
    logic [CNT_W-1:0] goto_len_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            goto_len_q <= '0;
        end else if (clk_en_i) begin
            if (tx_goto_a_o || tx_goto_b_o) begin
                goto_len_q <= goto_len_q + CNT_W'(1);
            end else begin
                goto_len_q <= '0;
            end
        end
    end
    // both switches share one command so they cannot diverge
    assign tx_goto_a_o = pulsing_w && !online_b_q;
    assign rx_goto_a_o = pulsing_w && !online_b_q;
    assign tx_goto_b_o = pulsing_w && online_b_q;
    assign rx_goto_b_o = pulsing_w && online_b_q;
    assign pos_a_oe_n_o = online_b_q;
    assign pos_b_oe_n_o = !online_b_q;
    assign pair_mode_a_oe_n_o = 1'b0;
    assign pair_mode_b_oe_n_o = 1'b0;
    assign b_addr_sel_oe_n_o  = 1'b0;
    assign switch_health_heartbeat_a_o = hb_q;
    assign switch_health_heartbeat_b_o = hb_q;
    assign first_online_contact_o  = !online_b_q;
    assign second_online_contact_o = online_b_q;
    assign unit_a_fault_contact_o  = a_faulted_w;
    assign unit_b_fault_contact_o  = b_faulted_w;
    // message content is handled elsewhere; lines pass between units and the host side
    assign aux_serial_to_unit_a_o = aux_serial_tx_a_i;
    assign aux_serial_to_unit_b_o = aux_serial_tx_b_i;
    assign aux_serial_rx_a_o = aux_serial_from_unit_a_i;
    assign aux_serial_rx_b_o = aux_serial_from_unit_b_i;
    assign manual_mode_o  = manual_w;
    assign switch_fault_o = sw_fault_q;
    assign online_b_o     = online_b_q;

    chk_pulse_length: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $fell(tx_goto_a_o || tx_goto_b_o) |-> (goto_len_q == CNT_W'(PULSE_CYCLES))
        ) else $error("command pulse length wrong");
    chk_switch_pair: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (tx_goto_a_o == rx_goto_a_o) && (tx_goto_b_o == rx_goto_b_o)
        ) else $error("Tx and Rx commands differ");
    chk_online_excl: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        first_online_contact_o != second_online_contact_o
        ) else $error("online contacts not exclusive");
    chk_pos_outputs: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        pos_a_oe_n_o == second_online_contact_o
        ) else $error("position A output disagrees with online unit");
    chk_hb_frozen: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        switch_fault_o && $past(switch_fault_o) |-> $stable(switch_health_heartbeat_a_o)
        ) else $error("heartbeat toggled during fault");
    chk_no_double_fault: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_q == RPS_IDLE) && !swap_evt_w && a_faulted_w && b_faulted_w && clk_en_i
        |=> $stable(online_b_q)
        ) else $error("swapped with both units faulted");
    chk_manual_swap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_q == RPS_IDLE) && swap_evt_w && manual_w && clk_en_i
        |=> (online_b_q != $past(online_b_q)) && pulsing_w
        ) else $error("manual swap request ignored");
    chk_fault_contacts: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        unit_a_fault_contact_o == deb_q[0]
        ) else $error("fault contact mismatch");
endmodule
`default_nettype wire

//--- verification/rps_switch_model.sv
// waveguide transfer switch model with active-low position indicators
`timescale 1ns/1ps
`default_nettype none
module rps_switch_model (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic goto_a_i,
    input  wire logic goto_b_i,
    input  wire logic stuck_i,
    output logic      ind_a_n_o,
    output logic      ind_b_n_o
);
    logic at_b_q;
    // a stuck rotor ignores the coil pulse, the only way this model misbehaves
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            at_b_q <= 1'b0;
        end else if (!stuck_i && goto_b_i) begin
            at_b_q <= 1'b1;
        end else if (!stuck_i && goto_a_i) begin
            at_b_q <= 1'b0;
        end
    end
    // only the reached position shorts its indicator to common
    assign ind_a_n_o = at_b_q;
    assign ind_b_n_o = !at_b_q;
endmodule
`default_nettype wire

//--- verification/rps_ctrl_tb_top.sv
// self-checking bench for the redundant pair switch controller
`timescale 1ns/1ps
`default_nettype none
module rps_ctrl_tb_top;
    localparam int PC = 20;
    logic clk = 0, rst_n = 0, h_a_n = 0, h_b_n = 0, sel_n = 1, swap_n = 1, stuck = 0;
    logic ax_a = 0, ax_b = 1, fr_a = 1, fr_b = 0;
    logic txa_n, txb_n, rxa_n, rxb_n, ga_t, gb_t, ga_r, gb_r, to_a, to_b, rx_a, rx_b;
    logic pa, pb, pma, pmb, bsel, hb_a, hb_b, on1, on2, fc_a, fc_b, man, sw_flt, on_b;
    int   n_mismatch = 0, n_compared = 0;
    always #25 clk = ~clk;
    rps_ctrl #(.PULSE_CYCLES(PC), .HB_CYCLES(16), .DEB_CYCLES(4)) i_rps_ctrl (
        .clk_sys_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .unit_a_health_in_n_i(h_a_n),
        .unit_b_health_in_n_i(h_b_n), .auto_manual_select_in_n_i(sel_n), .swap_req_n_i(swap_n),
        .tx_ind_a_n_i(txa_n), .tx_ind_b_n_i(txb_n), .rx_ind_a_n_i(rxa_n), .rx_ind_b_n_i(rxb_n),
        .aux_serial_tx_a_i(ax_a), .aux_serial_tx_b_i(ax_b), .aux_serial_from_unit_a_i(fr_a),
        .aux_serial_from_unit_b_i(fr_b), .aux_serial_to_unit_a_o(to_a),
        .aux_serial_to_unit_b_o(to_b), .aux_serial_rx_a_o(rx_a), .aux_serial_rx_b_o(rx_b),
        .tx_goto_a_o(ga_t), .tx_goto_b_o(gb_t), .rx_goto_a_o(ga_r), .rx_goto_b_o(gb_r),
        .pos_a_oe_n_o(pa), .pos_b_oe_n_o(pb), .pair_mode_a_oe_n_o(pma), .pair_mode_b_oe_n_o(pmb),
        .b_addr_sel_oe_n_o(bsel), .switch_health_heartbeat_a_o(hb_a),
        .switch_health_heartbeat_b_o(hb_b), .first_online_contact_o(on1),
        .second_online_contact_o(on2), .unit_a_fault_contact_o(fc_a),
        .unit_b_fault_contact_o(fc_b), .manual_mode_o(man), .switch_fault_o(sw_flt),
        .online_b_o(on_b));
    rps_switch_model i_rps_switch_model (.clk_sys_i(clk), .rst_n_i(rst_n), .goto_a_i(ga_t),
        .goto_b_i(gb_t), .stuck_i(stuck), .ind_a_n_o(txa_n), .ind_b_n_o(txb_n));
    rps_switch_model i_rps_switch_model_rx (.clk_sys_i(clk), .rst_n_i(rst_n), .goto_a_i(ga_r),
        .goto_b_i(gb_r), .stuck_i(1'b0), .ind_a_n_o(rxa_n), .ind_b_n_o(rxb_n));
    task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // held well past the debounce span, as a customer short would be
    task automatic swap_req();
        @(posedge clk) swap_n <= 1'b0;
        cyc(8);
        @(posedge clk) swap_n <= 1'b1;
    endtask
    task automatic pulse(input logic exp_b, input logic exp_flt);
        int n, len;
        n = 0;
        len = 0;
        while (ga_t !== 1'b1 && gb_t !== 1'b1 && n < 40) begin cyc(1); n++; end
        cmp({gb_t, ga_t, gb_r, ga_r}, {exp_b, !exp_b, exp_b, !exp_b});
        cmp({on_b, pa, pb, on1, on2}, {exp_b, exp_b, !exp_b, !exp_b, exp_b});
        while ((ga_t | gb_t) === 1'b1 && len < 100) begin cyc(1); len++; end
        cmp(len[7:0], 8'(PC));
        cyc(3);
        cmp(sw_flt, exp_flt);
    endtask
    task automatic quiet(input int n);
        int k;
        k = 0;
        repeat (n) begin cyc(1); if ((ga_t | gb_t | ga_r | gb_r) !== 1'b0) k++; end
        cmp(k[7:0], 8'h00);
    endtask
    task automatic t_static();
        cmp({pma, pmb, bsel}, 3'b000);
        cmp({fc_a, fc_b, man, on_b}, 4'b0000);
        cmp({to_a, to_b, rx_a, rx_b}, 4'b0110);
        @(posedge clk) begin ax_a <= 1; ax_b <= 0; fr_a <= 0; fr_b <= 1; end
        cyc(1);
        cmp({to_a, to_b, rx_a, rx_b}, 4'b1001);
        $display("test static done");
    endtask
    // manual swap goes through even toward a faulted unit, and no auto swap follows
    task automatic t_manual();
        @(posedge clk) begin sel_n <= 0; h_b_n <= 1; end
        cyc(8);
        cmp({man, fc_b, fc_a}, 3'b110);
        fork swap_req(); pulse(1, 0); join
        quiet(30);
        $display("test manual done");
    endtask
    task automatic t_auto();
        @(posedge clk) sel_n <= 1;
        pulse(0, 0);
        swap_req();
        quiet(20);
        @(posedge clk) h_a_n <= 1;
        quiet(30);
        cmp({fc_a, fc_b, on_b}, 3'b110);
        @(posedge clk) begin h_a_n <= 0; h_b_n <= 0; end
        cyc(8);
        fork swap_req(); pulse(1, 0); join
        $display("test auto done");
    endtask
    task automatic t_hb();
        int n;
        logic v;
        n = 0;
        @(posedge hb_a);
        cyc(1);
        cmp(hb_b, hb_a);
        while (hb_a === 1'b1 && n < 50) begin cyc(1); n++; end
        cmp(n[7:0], 8'h10);
        @(posedge clk) begin sel_n <= 0; stuck <= 1; end
        cyc(8);
        @(posedge clk) swap_n <= 1'b0;
        cyc(2);
        @(posedge clk) swap_n <= 1'b1;
        quiet(10);
        fork swap_req(); pulse(0, 1); join
        v = hb_a;
        n = 0;
        repeat (40) begin cyc(1); if (hb_a !== v) n++; end
        cmp(n[7:0], 8'h00);
        $display("test heartbeat done");
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        cyc(10);
        t_static();
        t_manual();
        t_auto();
        t_hb();
        test_done();
    end
    initial begin
        #(3000 * 50);
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
